// ---- core/hjd_core.sv ----
// Purpose: Decoder of acyclic parameter jobs for a heater controller
// Assumes: Master writes a job code, then the job bytes one by one
// Notes:
//
// Implementation choices: strobed register access and the register offsets.
`timescale 1ns/1ps
`include "hjd_params.svh"
module hjd_core
    import hjd_pkg::*;
(
    // Clock and reset
    input wire logic MCLK,
    input wire logic RESETN,
    // Register port
    input wire logic [3:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    // Measurement inputs from the line sensing pins
    input wire logic LINE_60HZ,
    input wire logic [15:0] ROT_FAULT,
    // Status outputs
    output logic READY,
    output logic SAT_ALARM,
    output logic IRQ
);
    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic [16:0] pin_meta;
    logic [16:0] pin_sync;
    // Two flops on every sensing pin
    always_ff @(posedge MCLK)
    begin
        pin_meta <= {LINE_60HZ, ROT_FAULT};
        pin_sync <= pin_meta;
    end

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    hjd_state_e state, next_state;
    logic [7:0] job, next_job;
    logic [3:0] idx, next_idx;
    logic [15:0] word, next_word;
    logic [7:0] fld, next_fld;
    logic [7:0] ftype, next_ftype;
    logic [15:0] cnt, next_cnt;
    logic [15:0] cur, next_cur;
    logic [15:0] last, next_last;
    logic [31:0] test_res, next_test_res;
    logic next_ready;
    logic [2:0] irq_stat, next_irq_stat;
    logic [2:0] irq_mask, next_irq_mask;
    logic [5:0] sel, next_sel;
    logic [7:0] next_rdata;
    logic next_sat;
    hjd_sp_s sp_q [`HJD_NCH];
    logic [6:0] fld_of [`HJD_NCH];
    logic [7:0] fprod [`HJD_NFLD];
    logic [7:0] fstby [`HJD_NFLD];
    logic sp_we;
    logic [5:0] sp_ch;
    logic [1:0] sp_kind;
    logic [7:0] sp_val;
    logic fa_we;
    logic [5:0] fa_ch;
    logic ff_we;
    logic ff_sb;
    logic [7:0] ev;
    logic bad;
    logic [15:0] ch_num;
    logic [7:0] scaled;
    logic [15:0] prod;

    // ------------------------------------------------------------------
    // Byte parser
    // ------------------------------------------------------------------
    logic wr_job;
    logic wr_dat;
    assign wr_job = WR && (ADDR == `HJD_REG_JOB);
    assign wr_dat = WR && (ADDR == `HJD_REG_DATA);
    assign ch_num = {word[7:0], WDATA};

    // Decode the next job byte into table updates
    always_comb
    begin
        next_state = state;
        next_job = job;
        next_idx = idx;
        next_word = word;
        next_fld = fld;
        next_ftype = ftype;
        next_cnt = cnt;
        next_cur = cur;
        next_last = last;
        next_test_res = test_res;
        next_ready = READY;
        sp_we = 1'b0;
        sp_ch = '0;
        sp_kind = 2'd0;
        sp_val = '0;
        fa_we = 1'b0;
        fa_ch = cur[5:0];
        ff_we = 1'b0;
        ff_sb = 1'b0;
        ev = '0;
        bad = 1'b0;
        if (wr_job)
        begin
            next_job = WDATA;
            next_idx = '0;
            next_state = HJD_HDR0;
        end
        else if (state == HJD_LIST)
        begin
            // One channel of a range per cycle
            fa_we = (cur[15:`HJD_CH_W] == '0);
            if (cur[15:`HJD_CH_W] != '0)
                bad = 1'b1;
            if ((cur + ((ftype == 8'd1) ? 16'd2 : 16'd1)) > last
                || cur >= last)
                next_state = HJD_HDR0;
            next_cur = cur + ((ftype == 8'd1) ? 16'd2 : 16'd1);
        end
        else if (wr_dat && state != HJD_IDLE)
        begin
            next_idx = idx + 4'd1;
            next_word = {word[7:0], WDATA};
            unique case (job)
                `HJD_JOB_TEST:
                begin
                    // Results overwrite the request bytes in place
                    unique case (idx[1:0])
                        2'd0: next_test_res[7:0] = (WDATA == 8'd1) ?
                            (pin_sync[16] ? `HJD_FREQ_60 : `HJD_FREQ_50)
                            : 8'd0;
                        2'd1: next_test_res[15:8] = WDATA;
                        2'd2: next_test_res[23:16] = WDATA;
                        default:
                        begin
                            next_test_res[31:24] = WDATA;
                            next_state = HJD_DONE;
                        end
                    endcase
                    if (idx[1:0] == 2'd3)
                    begin
                        // Mask the fault pins by selection
                        if (test_res[15:8] == 8'd1)
                            next_test_res[31:16] = {WDATA,
                                test_res[23:16]} & pin_sync[15:0];
                        else
                            next_test_res[31:16] = '0;
                        next_ready = 1'b1;
                        ev[`HJD_IRQ_JOB_DONE] = 1'b1;
                    end
                end
                `HJD_JOB_SP_STBY, `HJD_JOB_SP_PROF2, `HJD_JOB_SP_START:
                begin
                    // Channel high, channel low, setpoint
                    if (idx == 4'd2)
                    begin
                        next_idx = '0;
                        sp_ch = word[5:0];
                        sp_kind = job[1:0];
                        sp_val = WDATA;
                        if (word[15:`HJD_CH_W] != '0
                            || WDATA[6:0] > 7'd100)
                            bad = 1'b1;
                        else
                            sp_we = 1'b1;
                    end
                end
                `HJD_JOB_FPROD, `HJD_JOB_FSTBY:
                begin
                    if (idx == 4'd0)
                        next_fld = WDATA;
                    else
                    begin
                        next_idx = '0;
                        ff_sb = (job == `HJD_JOB_FSTBY);
                        if (fld == 8'd0 || fld[7])
                            bad = 1'b1;
                        else
                            ff_we = 1'b1;
                    end
                end
                `HJD_JOB_FIELD:
                begin
                    unique case (idx)
                        4'd0: next_fld = WDATA;
                        4'd1: next_ftype = WDATA;
                        4'd3: next_cur = ch_num;
                        4'd5:
                        begin
                            if (fld == 8'd0 || fld[7] || ftype > 8'd2)
                            begin
                                bad = 1'b1;
                                next_idx = '0;
                            end
                            else if (ftype == 8'd2)
                            begin
                                // First listed channel travels in index 4,5
                                fa_we = (cur != 16'd0)
                                    && (ch_num[15:`HJD_CH_W] == '0);
                                fa_ch = ch_num[5:0];
                                bad = (cur != 16'd0) && !fa_we;
                                next_cnt = cur - 16'd1;
                                next_idx = (cur <= 16'd1) ? 4'd0 : 4'd6;
                            end
                            else
                            begin
                                next_last = ch_num;
                                next_idx = '0;
                                next_state = HJD_LIST;
                            end
                        end
                        4'd7:
                        begin
                            // Listed channel
                            fa_we = (ch_num[15:`HJD_CH_W] == '0);
                            fa_ch = ch_num[5:0];
                            bad = !fa_we;
                            next_cnt = cnt - 16'd1;
                            next_idx = (cnt == 16'd1) ? 4'd0 : 4'd6;
                        end
                        default: ;
                    endcase
                end
                default: bad = 1'b1;
            endcase
        end
        if (bad)
            ev[`HJD_IRQ_BAD] = 1'b1;
    end

    // Register parser state
    always_ff @(posedge MCLK)
    begin
        if (!RESETN)
        begin
            state <= HJD_IDLE;
            job <= '0;
            idx <= '0;
            word <= '0;
            fld <= '0;
            ftype <= '0;
            cnt <= '0;
            cur <= '0;
            last <= '0;
            test_res <= '0;
        end
        else
        begin
            state <= next_state;
            job <= next_job;
            idx <= next_idx;
            word <= next_word;
            fld <= next_fld;
            ftype <= next_ftype;
            cnt <= next_cnt;
            cur <= next_cur;
            last <= next_last;
            test_res <= next_test_res;
        end
    end

    // ------------------------------------------------------------------
    // Tables
    // ------------------------------------------------------------------
    // Setpoints reset to 0 and factors to unity
    always_ff @(posedge MCLK)
    begin
        for (int i = 0; i < `HJD_NCH; i++)
        begin
            if (!RESETN)
            begin
                sp_q[i] <= '0;
                fld_of[i] <= '0;
            end
            else
            begin
                if (sp_we && sp_ch == 6'(i))
                begin
                    // Bit 7 stored as half-percent flag
                    unique case (sp_kind)
                        2'd0: sp_q[i].stby <= sp_val;
                        2'd1: sp_q[i].prof2 <= sp_val;
                        default: sp_q[i].start <= sp_val;
                    endcase
                end
                if (fa_we && fa_ch == 6'(i))
                    fld_of[i] <= fld[6:0];
            end
        end
        for (int f = 0; f < `HJD_NFLD; f++)
        begin
            if (!RESETN)
            begin
                fprod[f] <= `HJD_FACTOR_ONE;
                fstby[f] <= `HJD_FACTOR_ONE;
            end
            else if (ff_we && fld[6:0] == 7'(f))
            begin
                if (ff_sb)
                    fstby[f] <= WDATA;
                else
                    fprod[f] <= WDATA;
            end
        end
    end

    // ------------------------------------------------------------------
    // Scaling of the selected channel
    // ------------------------------------------------------------------
    logic [7:0] base;
    logic [7:0] fac;
    logic [7:0] spraw;
    logic [15:0] half_units;
    // Setpoint in half percent times factor in hundredths
    always_comb
    begin
        spraw = sp_q[sel].prof2;
        fac = fprod[fld_of[sel]];
        if (irq_mask[2] == 1'b0 && sel[0] == 1'b0)
        begin
            spraw = sp_q[sel].stby;
            fac = fstby[fld_of[sel]];
        end
        base = {spraw[6:0], 1'b0} + {7'd0, spraw[7]};
        if (fld_of[sel] == 7'd0)
            fac = `HJD_FACTOR_ONE;
        prod = base * fac;
        half_units = prod / 16'd100;
        next_sat = half_units > 16'(`HJD_FULL_SCALE);
        scaled = next_sat ? 8'(`HJD_FULL_SCALE) : half_units[7:0];
    end

    // ------------------------------------------------------------------
    // Register port and interrupt
    // ------------------------------------------------------------------
    // Sticky events, set wins over write-one clear
    always_comb
    begin
        next_irq_stat = irq_stat;
        next_irq_mask = irq_mask;
        next_sel = sel;
        if (WR && ADDR == `HJD_REG_IRQ_STAT)
            next_irq_stat = irq_stat & ~WDATA[2:0];
        if (WR && ADDR == `HJD_REG_IRQ_MASK)
            next_irq_mask = WDATA[2:0];
        if (WR && ADDR == `HJD_REG_SEL)
            next_sel = WDATA[5:0];
        next_irq_stat[`HJD_IRQ_JOB_DONE] |= ev[`HJD_IRQ_JOB_DONE];
        next_irq_stat[`HJD_IRQ_BAD] |= ev[`HJD_IRQ_BAD];
        next_irq_stat[`HJD_IRQ_SAT] |= next_sat;
        next_rdata = '0;
        if (RD)
        begin
            unique case (ADDR)
                `HJD_REG_JOB: next_rdata = job;
                `HJD_REG_STATUS: next_rdata = {6'd0, SAT_ALARM, READY};
                `HJD_REG_IRQ_STAT: next_rdata = {5'd0, irq_stat};
                `HJD_REG_IRQ_MASK: next_rdata = {5'd0, irq_mask};
                `HJD_REG_TEST_RES: next_rdata = test_res[8*idx[1:0] +: 8];
                `HJD_REG_SEL: next_rdata = {2'd0, sel};
                `HJD_REG_SCALED: next_rdata = scaled;
                `HJD_REG_MEAS: next_rdata = {1'b0, fld_of[sel]};
                default: next_rdata = '0;
            endcase
        end
    end

    // Register port flops and outputs
    always_ff @(posedge MCLK)
    begin
        if (!RESETN)
        begin
            irq_stat <= '0;
            irq_mask <= '0;
            sel <= '0;
            RDATA <= '0;
            READY <= 1'b0;
            SAT_ALARM <= 1'b0;
            IRQ <= 1'b0;
        end
        else
        begin
            irq_stat <= next_irq_stat;
            irq_mask <= next_irq_mask;
            sel <= next_sel;
            RDATA <= next_rdata;
            READY <= next_ready;
            SAT_ALARM <= next_sat;
            IRQ <= |(next_irq_stat & next_irq_mask);
        end
    end
endmodule // hjd_core

// ---- inc/hjd_params.svh ----
// Purpose: Constants for the heater job decoder
// Assumes: Included by the core, the checker and the bench
// Notes: Offsets are word indices on the plain register port
`ifndef HJD_PARAMS_SVH
`define HJD_PARAMS_SVH
// ----------------------------------------------------------------------
// Job codes
// ----------------------------------------------------------------------
`define HJD_JOB_TEST 8'h03
`define HJD_JOB_SP_STBY 8'h04
`define HJD_JOB_SP_PROF2 8'h05
`define HJD_JOB_SP_START 8'h06
`define HJD_JOB_FIELD 8'h07
`define HJD_JOB_FPROD 8'h08
`define HJD_JOB_FSTBY 8'h09
// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define HJD_REG_JOB 4'h0
`define HJD_REG_DATA 4'h1
`define HJD_REG_STATUS 4'h2
`define HJD_REG_IRQ_STAT 4'h3
`define HJD_REG_IRQ_MASK 4'h4
`define HJD_REG_TEST_RES 4'h5
`define HJD_REG_SEL 4'h6
`define HJD_REG_SCALED 4'h7
`define HJD_REG_MEAS 4'h8
// ----------------------------------------------------------------------
// Sizes, fields and values
// ----------------------------------------------------------------------
`define HJD_NCH 64
`define HJD_CH_W 6
`define HJD_NFLD 128
`define HJD_FULL_SCALE 9'd200
`define HJD_FACTOR_ONE 8'd100
`define HJD_FREQ_50 8'd50
`define HJD_FREQ_60 8'd60
`define HJD_IRQ_JOB_DONE 0
`define HJD_IRQ_SAT 1
`define HJD_IRQ_BAD 2
`endif

// ---- inc/hjd_pkg.sv ----
// Purpose: Types for the heater job decoder
// Assumes: Constants come from hjd_params.svh
// Notes: Parser state codes are Gray in declaration order; the parser never enters HDR1 or BODY
package hjd_pkg;
    typedef enum logic [2:0] {
        HJD_IDLE = 3'b000,
        HJD_HDR0 = 3'b001,
        HJD_HDR1 = 3'b011,
        HJD_BODY = 3'b010,
        HJD_LIST = 3'b110,
        HJD_DONE = 3'b111
    } hjd_state_e;
    typedef struct packed {
        logic [7:0] half;
        logic [7:0] stby;
        logic [7:0] prof2;
        logic [7:0] start;
    } hjd_sp_s;
endpackage

// ---- verification/hjd_core_checker.sv ----
// Purpose: Port checker for the heater job decoder
// Assumes: Bound to hjd_core, one clock domain
// Notes: Tracks job code and byte count to predict READY
`timescale 1ns/1ps
`include "hjd_params.svh"
module hjd_core_checker
(
    // Clock and reset
    input wire logic MCLK,
    input wire logic RESETN,
    // Register port
    input wire logic [3:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [7:0] RDATA,
    // Pins and status
    input wire logic LINE_60HZ,
    input wire logic [15:0] ROT_FAULT,
    input wire logic READY,
    input wire logic SAT_ALARM,
    input wire logic IRQ
);
    // --------------------------------
    // Job tracking
    // --------------------------------
    logic [7:0] job;
    logic [7:0] next_job;
    logic [1:0] cnt;
    logic [1:0] next_cnt;
    logic [7:0] fq;
    logic [7:0] next_fq;
    logic dwr;
    logic fin;
    logic rd5;
    logic rd7;
    logic rd2;
    // Decoded strobes
    assign dwr = WR && ADDR == `HJD_REG_DATA;
    assign fin = dwr && job == `HJD_JOB_TEST && cnt == 2'h3;
    assign rd5 = RD && ADDR == `HJD_REG_TEST_RES && job == `HJD_JOB_TEST
        && cnt == 2'h0 && fq == 8'h01;
    assign rd7 = RD && ADDR == `HJD_REG_SCALED;
    assign rd2 = RD && ADDR == `HJD_REG_STATUS;
    // Next job code, byte count and frequency request
    always_comb
    begin
        next_job = job;
        next_cnt = cnt;
        next_fq = fq;
        if (WR && ADDR == `HJD_REG_JOB)
        begin
            next_job = WDATA;
            next_cnt = 2'h0;
        end
        else if (dwr)
        begin
            next_cnt = cnt + 2'h1;
            if (job == `HJD_JOB_TEST && cnt == 2'h0)
                next_fq = WDATA;
        end
    end
    // Register the tracking state
    always_ff @(posedge MCLK)
    begin
        if (!RESETN)
        begin
            job <= 8'h00;
            cnt <= 2'h0;
            fq <= 8'h00;
        end
        else
        begin
            job <= next_job;
            cnt <= next_cnt;
            fq <= next_fq;
        end
    end
    // --------------------------------
    // Assertions
    // --------------------------------
    default clocking dc @(posedge MCLK);
    endclocking
    default disable iff (!RESETN);
    a_rdata_quiet: assert property (!$past(RD) |-> RDATA == 8'h00)
        else $error("read data outside the answer cycle");
    a_ready_holds: assert property (READY |=> READY)
        else $error("ready dropped without reset");
    a_ready_cause: assert property ($rose(READY) |-> $past(fin))
        else $error("ready rose without a full test job");
    a_ready_timely: assert property (fin && !READY |=> READY)
        else $error("ready late after the test job");
    a_scaled_cap: assert property ($past(rd7) |->
        RDATA <= `HJD_FULL_SCALE)
        else $error("scaled setpoint above full scale");
    a_freq_answer: assert property ($past(rd5) |->
        RDATA == `HJD_FREQ_50 || RDATA == `HJD_FREQ_60)
        else $error("frequency result neither 50 nor 60");
    a_reset_clears: assert property ($rose(RESETN) |->
        !READY && !IRQ && !SAT_ALARM && RDATA == 8'h00)
        else $error("outputs not cleared by reset");
    a_status_mirror: assert property ($past(rd2) |->
        RDATA[1:0] == {$past(SAT_ALARM), $past(READY)})
        else $error("status read differs from status pins");
    c_ready: cover property ($rose(READY));
    c_sat: cover property ($rose(SAT_ALARM));
    c_irq: cover property ($rose(IRQ));
endmodule // hjd_core_checker
bind hjd_core hjd_core_checker u_hjd_core_checker (.MCLK(MCLK),
    .RESETN(RESETN), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .LINE_60HZ(LINE_60HZ), .ROT_FAULT(ROT_FAULT),
    .READY(READY), .SAT_ALARM(SAT_ALARM), .IRQ(IRQ));

// ---- verification/hjd_line_model.sv ----
// Purpose: Line sensing pins seen by the decoder
// Assumes: Bench picks line frequency and fault pattern
// Notes: Pins move only on clock edges, like slow mains sensing
`timescale 1ns/1ps
module hjd_line_model
(
    // Clock
    input wire logic MCLK,
    // Settings from the bench
    input wire logic freq_60,
    input wire logic [15:0] fault_set,
    // Sensing pins
    output logic LINE_60HZ,
    output logic [15:0] ROT_FAULT
);
    // Register settings onto the pins
    always_ff @(posedge MCLK)
    begin
        LINE_60HZ <= freq_60;
        ROT_FAULT <= fault_set;
    end
endmodule // hjd_line_model

// ---- verification/hjd_core_bench.sv ----
// Purpose: Self-checking bench for the heater job decoder
// Assumes: Bench acts as the fieldbus master on the register port
// Notes: Fault bytes differ, so the result byte order is visible
`timescale 1ns/1ps
`include "hjd_params.svh"
module hjd_core_bench;
    // --------------------------------
    // Signals and instances
    // --------------------------------
    logic mclk;
    logic resetn;
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic [7:0] rdata;
    logic freq_60;
    logic [15:0] fault_set;
    logic line_60hz;
    logic [15:0] rot_fault;
    logic ready;
    logic sat_alarm;
    logic irq;
    int n_errors;
    int total_checks;
    int cycles;
    hjd_line_model u_hjd_line_model (.MCLK(mclk), .freq_60(freq_60),
        .fault_set(fault_set), .LINE_60HZ(line_60hz), .ROT_FAULT(rot_fault));
    hjd_core u_hjd_core (.MCLK(mclk), .RESETN(resetn), .ADDR(addr),
        .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
        .LINE_60HZ(line_60hz), .ROT_FAULT(rot_fault), .READY(ready),
        .SAT_ALARM(sat_alarm), .IRQ(irq));
    // 10 MHz clock and hang guard
    always #50 mclk = ~mclk;
    always @(posedge mclk)
    begin
        cycles = cycles + 1;
        if (cycles == 20000)
        begin
            n_errors = n_errors + 1;
            report_and_stop();
        end
    end
    // --------------------------------
    // Tasks
    // --------------------------------
    task automatic report_and_stop();
        if (n_errors == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic check(input string name, input logic [7:0] seen,
        input logic [7:0] exp);
        total_checks = total_checks + 1;
        if (seen !== exp)
        begin
            n_errors = n_errors + 1;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        rd <= 1'b0;
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
    endtask
    task automatic idle(input int n);
        repeat (n)
        begin
            @(posedge mclk);
            wr <= 1'b0;
            rd <= 1'b0;
        end
        #1;
    endtask
    task automatic rd_reg(input logic [3:0] a, input logic [7:0] m,
        input logic [7:0] exp, input string name);
        @(posedge mclk);
        wr <= 1'b0;
        rd <= 1'b1;
        addr <= a;
        @(posedge mclk);
        rd <= 1'b0;
        #1;
        check(name, rdata & m, exp);
    endtask
    task automatic job(input logic [7:0] code, input logic [7:0] b [$]);
        wr_reg(`HJD_REG_JOB, code);
        foreach (b[i])
            wr_reg(`HJD_REG_DATA, b[i]);
        idle(8);
    endtask
    // Full test job, then a partial one to walk the result index
    task automatic test_run(input logic [7:0] b0, input logic [7:0] b1,
        input logic [7:0] s, input int k, input logic [7:0] exp);
        logic [7:0] q [$];
        job(`HJD_JOB_TEST, '{b0, b1, s, s});
        for (int i = 0; i < k; i++)
            q.push_back(i == 0 ? b0 : (i == 1 ? b1 : s));
        job(`HJD_JOB_TEST, q);
        rd_reg(`HJD_REG_TEST_RES, 8'hff, exp, "test result");
    endtask
    task automatic sc_chk(input logic [7:0] ch, input logic [7:0] exp);
        wr_reg(`HJD_REG_SEL, ch);
        idle(3);
        rd_reg(`HJD_REG_SCALED, 8'hff, exp, "scaled");
    endtask
    // --------------------------------
    // Main sequence
    // --------------------------------
    initial
    begin
        logic [7:0] fch [12];
        logic [7:0] fex [12];
        fch = '{8'h03, 8'h04, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0c, 8'h14,
            8'h15, 8'h1f, 8'h18, 8'h28};
        fex = '{8'h00, 8'h01, 8'h01, 8'h00, 8'h02, 8'h00, 8'h02, 8'h03,
            8'h00, 8'h03, 8'h00, 8'h7f};
        mclk = 1'b0;
        resetn = 1'b0;
        addr = 4'h0;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        freq_60 = 1'b1;
        fault_set = 16'h5a3c;
        n_errors = 0;
        total_checks = 0;
        cycles = 0;
        repeat (10) @(posedge mclk);
        resetn <= 1'b1;
        idle(3);
        // Init hold, test job and interrupt handling
        check("ready", {7'h00, ready}, 8'h00);
        wr_reg(`HJD_REG_IRQ_MASK, 8'h00);
        job(`HJD_JOB_TEST, '{8'h01, 8'h01, 8'hff, 8'hff});
        check("ready", {7'h00, ready}, 8'h01);
        check("irq", {7'h00, irq}, 8'h00);
        rd_reg(`HJD_REG_IRQ_STAT, 8'h01, 8'h01, "irq status");
        wr_reg(`HJD_REG_IRQ_MASK, 8'h01);
        idle(3);
        check("irq", {7'h00, irq}, 8'h01);
        wr_reg(`HJD_REG_IRQ_STAT, 8'hff);
        idle(3);
        check("irq", {7'h00, irq}, 8'h00);
        rd_reg(4'h9, 8'hff, 8'h00, "unmapped");
        // Test results in the written byte slots
        test_run(8'h01, 8'h01, 8'hff, 0, 8'h3c);
        test_run(8'h01, 8'h01, 8'h0f, 2, 8'h0c);
        test_run(8'h01, 8'h01, 8'h0f, 3, 8'h0a);
        test_run(8'h01, 8'h00, 8'hff, 2, 8'h00);
        @(posedge mclk);
        freq_60 <= 1'b0;
        idle(4);
        test_run(8'h01, 8'h01, 8'hff, 0, 8'h32);
        test_run(8'h00, 8'h01, 8'hff, 0, 8'h00);
        // Setpoints, half steps, overwrite and refusal
        wr_reg(`HJD_REG_IRQ_MASK, 8'h03);
        sc_chk(8'h04, 8'h00);
        job(`HJD_JOB_SP_STBY, '{8'h00, 8'h04, 8'h28, 8'h00, 8'h06, 8'h9e});
        sc_chk(8'h04, 8'h50);
        sc_chk(8'h06, 8'h3d);
        job(`HJD_JOB_SP_PROF2, '{8'h00, 8'h07, 8'h9e});
        sc_chk(8'h07, 8'h3d);
        job(`HJD_JOB_SP_STBY, '{8'h00, 8'h04, 8'h64});
        sc_chk(8'h04, 8'hc8);
        wr_reg(`HJD_REG_IRQ_STAT, 8'hff);
        job(`HJD_JOB_SP_STBY, '{8'h00, 8'h04, 8'h65, 8'h01, 8'h04, 8'h0a});
        job(`HJD_JOB_SP_START, '{8'h00, 8'h04, 8'h14});
        sc_chk(8'h04, 8'hc8);
        rd_reg(`HJD_REG_IRQ_STAT, 8'h04, 8'h04, "bad entry");
        // Field allocation of all three types
        wr_reg(`HJD_REG_IRQ_STAT, 8'hff);
        job(`HJD_JOB_FIELD, '{8'h01, 8'h00, 8'h00, 8'h04, 8'h00, 8'h06});
        job(`HJD_JOB_FIELD, '{8'h02, 8'h01, 8'h00, 8'h08, 8'h00, 8'h0c});
        job(`HJD_JOB_FIELD, '{8'h03, 8'h02, 8'h00, 8'h02, 8'h00, 8'h14,
            8'h00, 8'h1f});
        job(`HJD_JOB_FIELD, '{8'h00, 8'h00, 8'h00, 8'h18, 8'h00, 8'h18});
        job(`HJD_JOB_FIELD, '{8'h7f, 8'h00, 8'h00, 8'h28, 8'h00, 8'h28});
        for (int i = 0; i < 12; i++)
        begin
            wr_reg(`HJD_REG_SEL, fch[i]);
            rd_reg(`HJD_REG_MEAS, 8'hff, fex[i], "field");
        end
        rd_reg(`HJD_REG_IRQ_STAT, 8'h04, 8'h04, "field zero");
        // Field factors and saturation
        job(`HJD_JOB_FSTBY, '{8'h01, 8'h32});
        sc_chk(8'h04, 8'h64);
        job(`HJD_JOB_SP_PROF2, '{8'h00, 8'h1f, 8'h3c});
        job(`HJD_JOB_FPROD, '{8'h03, 8'h96});
        sc_chk(8'h1f, 8'hb4);
        check("sat", {7'h00, sat_alarm}, 8'h00);
        wr_reg(`HJD_REG_IRQ_STAT, 8'hff);
        job(`HJD_JOB_SP_PROF2, '{8'h00, 8'h1f, 8'h50});
        sc_chk(8'h1f, 8'hc8);
        check("sat", {7'h00, sat_alarm}, 8'h01);
        rd_reg(`HJD_REG_STATUS, 8'h03, 8'h03, "status");
        rd_reg(`HJD_REG_IRQ_STAT, 8'h02, 8'h02, "sat event");
        check("irq", {7'h00, irq}, 8'h01);
        report_and_stop();
    end
endmodule // hjd_core_bench
